// ===== include/cct_pkg.sv
/*
 * Constants for the sixteen_bit_counter and its two compare units.
 * Assumes an 8-bit register port and one 100 MHz system clock.
 */
// Overview of operation
// - With counter_no_sync_n set, external edges count without instruction-cycle alignment.
// - Asynchronous counting continues in sleep; an overflow there raises a wake pulse.
// - Asynchronous counting disables the counter as compare time base.
// - Byte reads of the running count always return a settled value.
// - low_power_osc_enable runs the crystal amplifier, also during sleep.
// - Special-event compare mode clears the counter on a match.
// - A special event trigger never sets counter_overflow_flag.
// - A count byte write wins over a same-cycle trigger clear.
// - No reset clears the count bytes; only triggers do.
// - Power-on reset clears counter_control; other resets keep it.
// - Any count byte write clears the prescaler.
// - On equality the pin goes high, low or stays, per compare_mode_field.
// - compare_match_flag sets in the same cycle as the pin action.
// - Clearing compare_control forces the compare output latch low.
// - Software-interrupt mode leaves the pin and only sets the flag.
// - Unit two's trigger also starts a conversion when the converter is enabled.
package cct_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int INSTR_DIV = 4;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [3:0] A_COUNT_LOW = 4'h0;
    localparam logic [3:0] A_COUNT_HIGH = 4'h1;
    localparam logic [3:0] A_CTRL = 4'h2;
    localparam logic [3:0] A_FLAGS = 4'h3;
    localparam logic [3:0] A_CMP1_LOW = 4'h4;
    localparam logic [3:0] A_CMP1_HIGH = 4'h5;
    localparam logic [3:0] A_CMP1_CTRL = 4'h6;
    localparam logic [3:0] A_CMP2_LOW = 4'h7;
    localparam logic [3:0] A_CMP2_HIGH = 4'h8;
    localparam logic [3:0] A_CMP2_CTRL = 4'h9;
    // counter_control fields
    localparam int B_ON = 0;
    localparam int B_EXT_SRC = 1;
    localparam int B_NO_SYNC = 2;
    localparam int B_OSC_EN = 3;
    localparam int B_PS_LO = 4;
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [3:0] CMP_CTRL_RST = 4'h0;
    // Flag positions
    localparam int F_OVF = 0;
    localparam int F_CMP1 = 1;
    localparam int F_CMP2 = 2;
    // compare_mode_field codes
    localparam logic [3:0] M_SET_HIGH = 4'h8;
    localparam logic [3:0] M_SET_LOW = 4'h9;
    localparam logic [3:0] M_SW_INT = 4'ha;
    localparam logic [3:0] M_TRIGGER = 4'hb;
endpackage

// ===== include/cct_cmp_if.sv
/*
 * Link between the counter core and one compare unit.
 * Assumes both ends run on sys_clk.
 */
interface cct_cmp_if;
    logic [15:0] count;
    logic [15:0] value;
    logic [3:0] mode;
    logic timebase_ok;
    logic force_low;
    logic match;
    logic trigger;
    logic pin;
    modport core (output count, value, mode, timebase_ok, force_low,
                  input match, trigger, pin);
    modport unit (input count, value, mode, timebase_ok, force_low,
                  output match, trigger, pin);
endinterface

// ===== verilog/cct_compare.sv
/*
 * One compare unit: equality detect, pin latch, trigger.
 * Assumes count and settings change only on sys_clk edges.
 */
module cct_compare
    import cct_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_sync_n,
    // Core side
    cct_cmp_if.unit cmp
);
    logic eq_prev_reg, eq_prev_next;
    logic pin_reg, pin_next;
    logic eq, active;

    // Match is combinational so flag, pin and clear land on the same edge
    always_comb begin
        eq = (cmp.count == cmp.value);
        active = (cmp.mode[3:2] == 2'b10) && cmp.timebase_ok;
        cmp.match = active && eq && !eq_prev_reg;
        cmp.trigger = cmp.match && (cmp.mode == M_TRIGGER);
        cmp.pin = pin_reg;
        eq_prev_next = eq;
        pin_next = pin_reg;
        if (cmp.force_low) begin
            pin_next = 1'b0;
        end else if (cmp.match && cmp.mode == M_SET_HIGH) begin
            pin_next = 1'b1;
        end else if (cmp.match && cmp.mode == M_SET_LOW) begin
            pin_next = 1'b0;
        end
    end

    // Pin latch and equality history
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            eq_prev_reg <= 1'b0;
            pin_reg <= 1'b0;
        end else begin
            eq_prev_reg <= eq_prev_next;
            pin_reg <= pin_next;
        end
    end

    set_high_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        cmp.match && cmp.mode == M_SET_HIGH && !cmp.force_low |=> pin_reg)
        else $error("pin not driven high on match");
    force_low_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        cmp.force_low |=> !pin_reg)
        else $error("pin not forced low on control clear");
    sw_int_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        cmp.match && cmp.mode == M_SW_INT && !cmp.force_low |=> $stable(pin_reg))
        else $error("software interrupt mode moved the pin");
endmodule

// ===== verilog/cct_top.sv
/*
 * sixteen_bit_counter with prescaler, crystal amplifier and two compare units.
 * Assumes a register master on sys_clk; count and crystal pins are asynchronous.
 */
module cct_top
    import cct_pkg::*;
#(
    parameter int INSTR_DIVIDE = cct_pkg::INSTR_DIV
) (
    // Clock and resets
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic power_on_rst_n,
    // Register port
    input wire logic [cct_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [cct_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [cct_pkg::DATA_W-1:0] reg_rdata,
    // Processor state
    input wire logic sleep_req,
    input wire logic adc_enable,
    output logic wake_pulse,
    output logic adc_start,
    // Pins
    input wire logic ext_count_pin,
    input wire logic crystal_in_pin,
    output logic crystal_amp_out_pin,
    output logic compare_output_pin_one,
    output logic compare_output_pin_two
);
    import cct_pkg::*;

    // Divider counter is four bits wide, so ratios outside 2..16 cannot be served
    generate
        if (INSTR_DIVIDE < 2 || INSTR_DIVIDE > 16) begin : g_bad_div
            $error("INSTR_DIVIDE must be 2 to 16");
        end
    endgenerate

    // Reset release: general reset also follows power-on reset
    logic rst_m_reg, rst_sync_n;
    logic por_m_reg, por_sync_n;
    logic any_rst_n;
    assign any_rst_n = rst_n & power_on_rst_n;
    always_ff @(posedge sys_clk or negedge any_rst_n) begin
        if (!any_rst_n) begin
            rst_m_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_m_reg <= 1'b1;
            rst_sync_n <= rst_m_reg;
        end
    end
    always_ff @(posedge sys_clk or negedge power_on_rst_n) begin
        if (!power_on_rst_n) begin
            por_m_reg <= 1'b0;
            por_sync_n <= 1'b0;
        end else begin
            por_m_reg <= 1'b1;
            por_sync_n <= por_m_reg;
        end
    end

    // Pin synchronisers; only the second stage and later are read by logic
    logic ext_m_reg, ext_s_reg, ext_d_reg;
    logic xtal_m_reg, xtal_s_reg;
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ext_m_reg <= 1'b0;
            ext_s_reg <= 1'b0;
            ext_d_reg <= 1'b0;
            xtal_m_reg <= 1'b0;
            xtal_s_reg <= 1'b0;
        end else begin
            ext_m_reg <= ext_count_pin;
            ext_s_reg <= ext_m_reg;
            ext_d_reg <= ext_s_reg;
            xtal_m_reg <= crystal_in_pin;
            xtal_s_reg <= xtal_m_reg;
        end
    end

    // Register state
    logic [5:0] ctrl_reg, ctrl_next;
    logic [15:0] count_reg, count_next;
    logic [2:0] pre_reg, pre_next;
    logic [3:0] div_reg, div_next;
    logic pend_reg, pend_next;
    logic [2:0] flags_reg, flags_next;
    logic [15:0] cv1_reg, cv1_next, cv2_reg, cv2_next;
    logic [3:0] cm1_reg, cm1_next, cm2_reg, cm2_next;
    logic [7:0] rdata_next;
    logic wake_next, adc_next, amp_next;

    // Decoded strobes
    logic wr_lo, wr_hi, wr_cnt, wr_ctrl, wr_flags;
    assign wr_lo = reg_wr && reg_addr == A_COUNT_LOW;
    assign wr_hi = reg_wr && reg_addr == A_COUNT_HIGH;
    assign wr_cnt = wr_lo || wr_hi;
    assign wr_ctrl = reg_wr && reg_addr == A_CTRL;
    assign wr_flags = reg_wr && reg_addr == A_FLAGS;

    // Control fields
    logic ctr_on, ext_src, no_sync, osc_en;
    logic [1:0] ps_sel;
    assign ctr_on = ctrl_reg[B_ON];
    assign ext_src = ctrl_reg[B_EXT_SRC];
    assign no_sync = ctrl_reg[B_NO_SYNC];
    assign osc_en = ctrl_reg[B_OSC_EN];
    assign ps_sel = ctrl_reg[B_PS_LO+1:B_PS_LO];

    // Compare units
    cct_cmp_if cif1();
    cct_cmp_if cif2();
    logic async_mode;
    assign async_mode = ext_src && no_sync;
    assign cif1.count = count_reg;
    assign cif1.value = cv1_reg;
    assign cif1.mode = cm1_reg;
    assign cif1.timebase_ok = !async_mode;
    assign cif1.force_low = reg_wr && reg_addr == A_CMP1_CTRL && reg_wdata[3:0] == 4'h0;
    assign cif2.count = count_reg;
    assign cif2.value = cv2_reg;
    assign cif2.mode = cm2_reg;
    assign cif2.timebase_ok = !async_mode;
    assign cif2.force_low = reg_wr && reg_addr == A_CMP2_CTRL && reg_wdata[3:0] == 4'h0;
    cct_compare u_cmp1 (.sys_clk(sys_clk), .rst_sync_n(rst_sync_n), .cmp(cif1));
    cct_compare u_cmp2 (.sys_clk(sys_clk), .rst_sync_n(rst_sync_n), .cmp(cif2));

    // Count source, prescaler and increment
    logic div_hit, ext_rise, base_tick, pre_hit, inc, wrap, trig, run;
    logic [2:0] pre_mask;
    always_comb begin
        div_hit = (div_reg == 4'(INSTR_DIVIDE - 1));
        div_next = div_hit ? 4'h0 : div_reg + 4'h1;
        // The crystal only drives its amplifier here and never counts, so
        // the count pin is ignored while the oscillator is enabled
        ext_rise = osc_en ? 1'b0 : (ext_s_reg && !ext_d_reg);
        pend_next = pend_reg;
        base_tick = 1'b0;
        // Sleep stops all but asynchronous counting
        run = ctr_on && (!sleep_req || async_mode);
        if (!ext_src) begin
            base_tick = div_hit;
            pend_next = 1'b0;
        end else if (no_sync) begin
            base_tick = ext_rise;
            pend_next = 1'b0;
        end else begin
            // Synchronized mode holds an edge until the next instruction cycle
            pend_next = (pend_reg || ext_rise) && !div_hit;
            base_tick = (pend_reg || ext_rise) && div_hit;
        end
        base_tick = base_tick && run;
        pre_mask = (3'h1 << ps_sel) - 3'h1;
        pre_hit = base_tick && ((pre_reg & pre_mask) == pre_mask);
        pre_next = pre_reg;
        if (base_tick) begin
            pre_next = pre_hit ? 3'h0 : pre_reg + 3'h1;
        end
        if (wr_cnt || wr_ctrl) begin
            pre_next = 3'h0;
        end
        inc = pre_hit;
        wrap = inc && count_reg == 16'hffff;
        trig = cif1.trigger || cif2.trigger;
    end

    // Count pair: write beats trigger clear, which beats increment
    always_comb begin
        count_next = count_reg;
        if (inc) begin
            count_next = count_reg + 16'h0001;
        end
        if (trig) begin
            count_next = 16'h0000;
        end
        if (wr_lo) begin
            count_next = {(trig ? 8'h00 : count_next[15:8]), reg_wdata};
        end
        if (wr_hi) begin
            count_next = {reg_wdata, (trig ? 8'h00 : count_next[7:0])};
        end
    end

    // Count bytes carry no reset at all
    always_ff @(posedge sys_clk) begin
        count_reg <= count_next;
    end

    // counter_control follows power-on reset only
    always_comb begin
        ctrl_next = wr_ctrl ? reg_wdata[5:0] : ctrl_reg;
    end
    always_ff @(posedge sys_clk or negedge por_sync_n) begin
        if (!por_sync_n) begin
            ctrl_reg <= CTRL_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Compare values carry no reset; modes clear on every reset
    always_comb begin
        cv1_next = cv1_reg;
        cv2_next = cv2_reg;
        cm1_next = cm1_reg;
        cm2_next = cm2_reg;
        if (reg_wr) begin
            unique case (reg_addr)
                A_CMP1_LOW: cv1_next[7:0] = reg_wdata;
                A_CMP1_HIGH: cv1_next[15:8] = reg_wdata;
                A_CMP1_CTRL: cm1_next = reg_wdata[3:0];
                A_CMP2_LOW: cv2_next[7:0] = reg_wdata;
                A_CMP2_HIGH: cv2_next[15:8] = reg_wdata;
                A_CMP2_CTRL: cm2_next = reg_wdata[3:0];
                default: cv1_next = cv1_reg;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        cv1_reg <= cv1_next;
        cv2_reg <= cv2_next;
    end

    // Flags: write one to clear, a same-cycle event wins
    always_comb begin
        flags_next = flags_reg;
        if (wr_flags) begin
            flags_next = flags_reg & ~reg_wdata[2:0];
        end
        if (wrap) begin
            flags_next[F_OVF] = 1'b1;
        end
        if (cif1.match) begin
            flags_next[F_CMP1] = 1'b1;
        end
        if (cif2.match) begin
            flags_next[F_CMP2] = 1'b1;
        end
    end

    // Read mux; the count is already in this clock domain, so bytes are settled
    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                A_COUNT_LOW: rdata_next = count_reg[7:0];
                A_COUNT_HIGH: rdata_next = count_reg[15:8];
                A_CTRL: rdata_next = {2'b00, ctrl_reg};
                A_FLAGS: rdata_next = {5'h00, flags_reg};
                A_CMP1_LOW: rdata_next = cv1_reg[7:0];
                A_CMP1_HIGH: rdata_next = cv1_reg[15:8];
                A_CMP1_CTRL: rdata_next = {4'h0, cm1_reg};
                A_CMP2_LOW: rdata_next = cv2_reg[7:0];
                A_CMP2_HIGH: rdata_next = cv2_reg[15:8];
                A_CMP2_CTRL: rdata_next = {4'h0, cm2_reg};
                default: rdata_next = 8'h00;
            endcase
        end
        wake_next = wrap && sleep_req;
        adc_next = cif2.trigger && adc_enable;
        // Amplifier inverts the crystal input while enabled, sleep or not
        amp_next = osc_en && !xtal_s_reg;
    end

    // Remaining control state
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            div_reg <= 4'h0;
            pre_reg <= 3'h0;
            pend_reg <= 1'b0;
            flags_reg <= 3'h0;
            cm1_reg <= CMP_CTRL_RST;
            cm2_reg <= CMP_CTRL_RST;
            reg_rdata <= 8'h00;
            wake_pulse <= 1'b0;
            adc_start <= 1'b0;
            crystal_amp_out_pin <= 1'b0;
        end else begin
            div_reg <= div_next;
            pre_reg <= pre_next;
            pend_reg <= pend_next;
            flags_reg <= flags_next;
            cm1_reg <= cm1_next;
            cm2_reg <= cm2_next;
            reg_rdata <= rdata_next;
            wake_pulse <= wake_next;
            adc_start <= adc_next;
            crystal_amp_out_pin <= amp_next;
        end
    end
    assign compare_output_pin_one = cif1.pin;
    assign compare_output_pin_two = cif2.pin;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_n);
    ovf_flag_a: assert property (wrap |=> flags_reg[F_OVF])
        else $error("overflow flag missed on wrap");
    trig_no_ovf_a: assert property (trig && !wrap && !flags_reg[F_OVF]
        |=> !flags_reg[F_OVF])
        else $error("trigger set overflow flag");
    trig_clear_a: assert property (trig && !wr_cnt |=> count_reg == 16'h0000)
        else $error("trigger did not clear count");
    write_wins_a: assert property (trig && wr_lo
        |=> count_reg == {8'h00, $past(reg_wdata)})
        else $error("trigger beat software write");
    pre_clear_a: assert property (wr_cnt |=> pre_reg == 3'h0)
        else $error("prescaler not cleared on count write");
    async_tb_a: assert property (async_mode |-> !cif1.match && !cif2.match)
        else $error("async count used as compare base");
    match_flag_a: assert property (cif1.match |=> flags_reg[F_CMP1])
        else $error("match flag not set with pin action");
    adc_start_a: assert property (cif2.trigger && adc_enable |=> adc_start ##1 !adc_start)
        else $error("conversion start missing");
    sleep_hold_a: assert property (sleep_req && !async_mode && !wr_cnt && !trig
        |=> count_reg == $past(count_reg))
        else $error("synchronous count ran in sleep");
    wake_a: assert property (wrap && sleep_req |=> wake_pulse)
        else $error("no wake on sleep overflow");
    async_tick_a: assert property (run && async_mode && ext_rise && ps_sel == 2'b00
        && !wr_cnt && !trig |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("external edge not counted directly");
    amp_off_a: assert property (!osc_en |=> !crystal_amp_out_pin)
        else $error("crystal amplifier ran while disabled");
    adc_quiet_a: assert property (!(cif2.trigger && adc_enable) |=> !adc_start)
        else $error("conversion start without unit two trigger");
    ovf_hold_a: assert property (flags_reg[F_OVF] && !(wr_flags && reg_wdata[F_OVF])
        |=> flags_reg[F_OVF])
        else $error("overflow flag dropped without software clear");
    match2_flag_a: assert property (cif2.match |=> flags_reg[F_CMP2])
        else $error("unit two match flag not set");
    force_low2_a: assert property (cif2.force_low |=> !compare_output_pin_two)
        else $error("unit two pin not forced low");

    // Main scenarios reached by the bench
    trig_cov: cover property (trig ##1 count_reg == 16'h0000);
    wrap_cov: cover property (wrap ##1 flags_reg[F_OVF]);
    adc_cov: cover property (adc_start);
    write_wins_cov: cover property (trig && wr_lo);
    wake_cov: cover property (wake_pulse);
endmodule

// ===== tb/cct_ext_model.sv
/*
 * Far-side model: external count source and crystal input.
 * Assumes the bench calls its tasks; edges are timed apart from sys_clk.
 */
module cct_ext_model (
    // Pins toward the counter
    output logic ext_count_pin,
    output logic crystal_in_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    // Both pins idle low until a task moves them
    initial begin
        ext_count_pin = 1'b0;
        crystal_in_pin = 1'b0;
    end
    // Odd delays keep edges out of step with sys_clk, as a real source would be
    task automatic pulse_count(input int n);
        for (int i = 0; i < n; i++) begin
            #37 ext_count_pin = 1'b1;
            #43 ext_count_pin = 1'b0;
        end
    endtask
    // Static crystal level; the amplifier output is its inverse
    task automatic set_crystal(input logic v);
        crystal_in_pin = v;
    endtask
endmodule

// ===== tb/counter16_compare_trigger_tb.sv
/*
 * Self-checking bench for cct_top: registers, compare modes, trigger, resets.
 * Assumes cct_pkg and the external source model are compiled first.
 */
module counter16_compare_trigger_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import cct_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic power_on_rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic sleep_req = 1'b0;
    logic adc_enable = 1'b0;
    logic wake_pulse, adc_start, ext_count_pin, crystal_in_pin;
    logic crystal_amp_out_pin, pin1, pin2;
    logic [7:0] d;
    int fail_count = 0;
    int checks_done = 0;
    int adc_seen = 0;
    int wake_seen = 0;

    cct_top #(.INSTR_DIVIDE(4)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .power_on_rst_n(power_on_rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sleep_req(sleep_req), .adc_enable(adc_enable),
        .wake_pulse(wake_pulse), .adc_start(adc_start), .ext_count_pin(ext_count_pin),
        .crystal_in_pin(crystal_in_pin), .crystal_amp_out_pin(crystal_amp_out_pin),
        .compare_output_pin_one(pin1), .compare_output_pin_two(pin2)
    );
    cct_ext_model u_ext (.ext_count_pin(ext_count_pin), .crystal_in_pin(crystal_in_pin));

    always #5 sys_clk = ~sys_clk;
    // Pulse outputs stand one cycle, so count them at every edge
    always @(posedge sys_clk) begin
        if (adc_start === 1'b1) begin
            adc_seen++;
        end
        if (wake_pulse === 1'b1) begin
            wake_seen++;
        end
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus cycles: one strobe cycle each, read data sampled in the following cycle
    task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    // Low byte first, high byte at the next index
    task automatic load16(input logic [3:0] a, input logic [15:0] v);
        reg_write(a, v[7:0]);
        reg_write(a + 4'h1, v[15:8]);
    endtask
    // Polls the flag register; a flag that never comes ends the run
    task automatic wait_flag(input int bitn);
        logic [7:0] f;
        for (int n = 0; n < 100; n++) begin
            reg_read(A_FLAGS, f);
            if (f[bitn] === 1'b1) begin
                return;
            end
        end
        fail_count++;
        tally_and_finish();
    endtask
    task automatic pulse_reset(input logic por);
        if (por) begin
            power_on_rst_n <= 1'b0;
        end else begin
            rst_n <= 1'b0;
        end
        repeat (3) @(posedge sys_clk);
        power_on_rst_n <= 1'b1;
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic t_power_up();
        reg_read(A_CTRL, d);
        check_byte(d, 8'h00);
        reg_read(4'hf, d);
        check_byte(d, 8'h00);
    endtask
    task automatic t_overflow();
        reg_write(A_CTRL, 8'h00);
        load16(A_COUNT_LOW, 16'hfffe);
        reg_write(A_FLAGS, 8'h07);
        reg_write(A_CTRL, 8'h01);
        wait_flag(F_OVF);
        reg_write(A_CTRL, 8'h00);
        reg_read(A_COUNT_HIGH, d);
        check_byte(d, 8'h00);
        reg_write(A_FLAGS, 8'h01);
        reg_read(A_FLAGS, d);
        check_byte(d, 8'h00);
    endtask
    // Restart from zero each time so the match lands after a known run
    task automatic t_compare_modes();
        logic [3:0] modes [4] = '{M_SET_HIGH, M_SW_INT, M_SET_LOW, M_SET_HIGH};
        logic pins [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            reg_write(A_CTRL, 8'h00);
            load16(A_COUNT_LOW, 16'h0000);
            load16(A_CMP1_LOW, 16'h0010);
            reg_write(A_CMP1_CTRL, {4'h0, modes[i]});
            reg_write(A_FLAGS, 8'h07);
            reg_write(A_CTRL, 8'h01);
            wait_flag(F_CMP1);
            check_bit(pin1, pins[i]);
        end
        reg_write(A_CMP1_CTRL, 8'h00);
        #1;
        check_bit(pin1, 1'b0);
        // Unit two drives its own pin the same way
        reg_write(A_CTRL, 8'h00);
        load16(A_COUNT_LOW, 16'h0000);
        load16(A_CMP2_LOW, 16'h0010);
        reg_write(A_CMP2_CTRL, {4'h0, M_SET_HIGH});
        reg_write(A_FLAGS, 8'h07);
        reg_write(A_CTRL, 8'h01);
        wait_flag(F_CMP2);
        check_bit(pin2, 1'b1);
        reg_write(A_CMP2_CTRL, 8'h00);
        #1;
        check_bit(pin2, 1'b0);
        reg_write(A_CTRL, 8'h00);
    endtask
    task automatic t_trigger();
        reg_write(A_CTRL, 8'h00);
        load16(A_COUNT_LOW, 16'h0000);
        load16(A_CMP2_LOW, 16'h0010);
        reg_write(A_CMP2_CTRL, {4'h0, M_TRIGGER});
        reg_write(A_FLAGS, 8'h07);
        adc_enable <= 1'b1;
        adc_seen = 0;
        reg_write(A_CTRL, 8'h01);
        wait_flag(F_CMP2);
        reg_read(A_COUNT_HIGH, d);
        check_byte(d, 8'h00);
        reg_read(A_COUNT_LOW, d);
        check_bit(d < 8'h08, 1'b1);
        check_bit(adc_seen > 0, 1'b1);
        reg_read(A_FLAGS, d);
        check_bit(d[F_OVF], 1'b0);
        // A count byte write in the very cycle of the trigger must win
        reg_write(A_CTRL, 8'h00);
        load16(A_COUNT_LOW, 16'h0005);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= A_CMP2_LOW;
        reg_wdata <= 8'h05;
        @(posedge sys_clk);
        reg_addr <= A_COUNT_LOW;
        reg_wdata <= 8'h33;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_read(A_COUNT_LOW, d);
        check_byte(d, 8'h33);
        reg_read(A_COUNT_HIGH, d);
        check_byte(d, 8'h00);
        reg_write(A_CMP2_CTRL, 8'h00);
        adc_enable <= 1'b0;
    endtask
    // Unsynchronised external counting through a wrap while asleep
    task automatic t_async();
        reg_write(A_CTRL, 8'h00);
        load16(A_COUNT_LOW, 16'hffff);
        load16(A_CMP1_LOW, 16'h0001);
        reg_write(A_CMP1_CTRL, {4'h0, M_SW_INT});
        reg_write(A_FLAGS, 8'h07);
        wake_seen = 0;
        sleep_req <= 1'b1;
        reg_write(A_CTRL, 8'h07);
        u_ext.pulse_count(3);
        repeat (8) @(posedge sys_clk);
        sleep_req <= 1'b0;
        reg_write(A_CTRL, 8'h00);
        reg_read(A_COUNT_LOW, d);
        check_byte(d, 8'h02);
        reg_read(A_FLAGS, d);
        check_byte(d, 8'h01);
        check_bit(wake_seen > 0, 1'b1);
        reg_write(A_CMP1_CTRL, 8'h00);
    endtask
    task automatic t_osc();
        u_ext.set_crystal(1'b0);
        sleep_req <= 1'b1;
        reg_write(A_CTRL, 8'h08);
        repeat (4) @(posedge sys_clk);
        #1;
        check_bit(crystal_amp_out_pin, 1'b1);
        u_ext.set_crystal(1'b1);
        repeat (4) @(posedge sys_clk);
        #1;
        check_bit(crystal_amp_out_pin, 1'b0);
        reg_write(A_CTRL, 8'h00);
        sleep_req <= 1'b0;
    endtask
    // General reset keeps control and count; power-on clears control but keeps count
    task automatic t_resets();
        reg_write(A_CTRL, 8'h30);
        load16(A_COUNT_LOW, 16'h1234);
        pulse_reset(1'b0);
        reg_read(A_CTRL, d);
        check_byte(d, 8'h30);
        reg_read(A_COUNT_LOW, d);
        check_byte(d, 8'h34);
        pulse_reset(1'b1);
        reg_read(A_CTRL, d);
        check_byte(d, 8'h00);
        reg_read(A_COUNT_HIGH, d);
        check_byte(d, 8'h12);
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        power_on_rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_power_up();
        t_overflow();
        t_compare_modes();
        t_trigger();
        t_async();
        t_osc();
        t_resets();
        tally_and_finish();
    end
endmodule
